// file: src/eee_regs.sv
/*
 Low-power-idle management register set behind an AXI4-Lite slave.
 Assumes line status inputs synchronous to aclk and a master with at most
 one read and one write outstanding.
*/
`timescale 1ns/1ps
`include "eee_consts.svh"
module eee_regs
   import eee_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire eee_line_t line_in,
   input wire logic adv_strap,
   output eee_mac_t mac_out,
   output logic irq
);
   logic aw_held_ff, w_held_ff;
   logic [15:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   eee_wstate_t wst_ff;
   logic wr_go;
   logic [15:0] widx, ridx;
   logic strap_done_ff;
   logic soft_rst;
   logic pcs_rst_ff, rxclk_stop_ff, tx_rcvd_ff, rx_rcvd_ff, adv_ff, lp_ff;
   logic [15:0] vend_ff, wake_ff, rd_mux;
   logic [3:0] irq_stat_ff, irq_en_ff, irq_ev;
   logic rd_hit, wake_rd;
   logic wr_lo, wr_hi;

   assign widx = waddr_ff;
   assign ridx = s_axi_araddr[17:2];
   assign wr_go = (wst_ff == EEE_W_IDLE) && aw_held_ff && w_held_ff;
   assign wr_lo = wstrb_ff[0];
   assign wr_hi = wstrb_ff[1];
   assign soft_rst = pcs_rst_ff;

   // Write address and data captured in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         waddr_ff <= 16'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         waddr_ff <= s_axi_awaddr[17:2];
      end else if (wr_go) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_ff <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready = !w_held_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_ff <= EEE_W_IDLE;
      end else begin
         case (wst_ff)
            EEE_W_IDLE: if (wr_go) wst_ff <= EEE_W_RESP;
            EEE_W_RESP: if (s_axi_bready) wst_ff <= EEE_W_IDLE;
            EEE_W_HOLD: wst_ff <= EEE_W_IDLE;
            default: wst_ff <= EEE_W_IDLE;
         endcase
      end
   end
   assign s_axi_bvalid = (wst_ff == EEE_W_RESP);
   assign s_axi_bresp = 2'b00;

   // Strap caught at the first edge after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_done_ff <= 1'b0;
      end else begin
         strap_done_ff <= 1'b1;
      end
   end

   // Self-clearing soft reset bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pcs_rst_ff <= 1'b0;
      end else if (wr_go && wr_hi && widx == `EEE_IDX_PCS_CTRL) begin
         pcs_rst_ff <= wdata_ff[`EEE_BIT_PCS_RST];
      end else begin
         pcs_rst_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         rxclk_stop_ff <= 1'b1;
      end else if (wr_go && wr_hi && widx == `EEE_IDX_PCS_CTRL) begin
         rxclk_stop_ff <= wdata_ff[`EEE_BIT_RXCLK_STOP];
      end
   end

   // Latched idle-received bits; set wins over soft reset clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_rcvd_ff <= 1'b0;
         rx_rcvd_ff <= 1'b0;
      end else begin
         tx_rcvd_ff <= line_in.tx_lpi | (tx_rcvd_ff & !soft_rst);
         rx_rcvd_ff <= line_in.rx_lpi | (rx_rcvd_ff & !soft_rst);
      end
   end

   // Advertisement, default from strap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adv_ff <= 1'b1;
      end else if (!strap_done_ff || soft_rst) begin
         adv_ff <= adv_strap;
      end else if (wr_go && wr_lo && widx == `EEE_IDX_ADVERT) begin
         adv_ff <= wdata_ff[`EEE_BIT_ADV_100];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         lp_ff <= 1'b0;
      end else begin
         lp_ff <= line_in.partner_adv_100 & vend_ff[`EEE_BIT_VEND_CAP_EN];
      end
   end

   // Vendor configuration untouched by soft reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vend_ff <= `EEE_RST_VEND_CFG;
      end else if (wr_go && widx == `EEE_IDX_VEND_CFG) begin
         if (wr_lo) vend_ff[7:0] <= wdata_ff[7:0] & 8'(`EEE_VEND_WR_MASK);
         if (wr_hi) vend_ff[15:8] <= wdata_ff[15:8];
         if (wr_lo) vend_ff[`EEE_BIT_VEND_BYPASS] <= wdata_ff[`EEE_BIT_VEND_BYPASS];
         if (wr_lo) vend_ff[`EEE_BIT_VEND_CAP_EN] <= wdata_ff[`EEE_BIT_VEND_CAP_EN];
      end
   end

   // Wake-error counter: saturate, clear on read, a fault in the read cycle restarts the count at one
   assign wake_rd = s_axi_arvalid && s_axi_arready && ridx == `EEE_IDX_WAKE_ERR;
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         wake_ff <= 16'h0000;
      end else if (line_in.wake_fail) begin
         if (wake_rd) wake_ff <= 16'h0001;
         else if (wake_ff != `EEE_WAKE_MAX) wake_ff <= wake_ff + 16'h0001;
      end else if (wake_rd) begin
         wake_ff <= 16'h0000;
      end
   end

   // Interrupt: tx idle, rx idle, wake fail, partner advert events
   assign irq_ev = {line_in.tx_lpi, line_in.rx_lpi, line_in.wake_fail, lp_ff};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= 4'h0;
      end else if (wr_go && wr_lo && widx == `EEE_IDX_IRQ_CLR) begin
         irq_stat_ff <= irq_ev | (irq_stat_ff & ~wdata_ff[3:0]);
      end else begin
         irq_stat_ff <= irq_ev | irq_stat_ff;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_ff <= 4'h0;
      end else if (wr_go && wr_lo && widx == `EEE_IDX_IRQ_EN) begin
         irq_en_ff <= wdata_ff[3:0];
      end
   end
   assign irq = |(irq_stat_ff & irq_en_ff);

   // Read mux; unmapped reads give zero with SLVERR
   always_comb begin
      rd_mux = 16'h0000;
      rd_hit = 1'b1;
      case (ridx)
         `EEE_IDX_LOOP_BW3: rd_mux = `EEE_RST_LOOP_BW3;
         `EEE_IDX_VEND_CFG: rd_mux = vend_ff;
         `EEE_IDX_PCS_CTRL: rd_mux[`EEE_BIT_RXCLK_STOP] = rxclk_stop_ff;
         `EEE_IDX_PCS_STAT: begin
            rd_mux[`EEE_BIT_TX_LPI_RCVD] = tx_rcvd_ff;
            rd_mux[`EEE_BIT_RX_LPI_RCVD] = rx_rcvd_ff;
            rd_mux[`EEE_BIT_TX_LPI_NOW] = line_in.tx_lpi;
            rd_mux[`EEE_BIT_RX_LPI_NOW] = line_in.rx_lpi;
            rd_mux[`EEE_BIT_TXCLK_STOP] = 1'b1;
         end
         `EEE_IDX_CAPAB: rd_mux[`EEE_BIT_CAP_100] = 1'b1;
         `EEE_IDX_WAKE_ERR: rd_mux = wake_ff;
         `EEE_IDX_ADVERT: rd_mux[`EEE_BIT_ADV_100] = adv_ff;
         `EEE_IDX_PARTNER: rd_mux[`EEE_BIT_LP_100] = lp_ff;
         `EEE_IDX_IRQ_STAT: rd_mux[3:0] = irq_stat_ff;
         `EEE_IDX_IRQ_EN: rd_mux[3:0] = irq_en_ff;
         `EEE_IDX_IRQ_CLR: rd_mux = 16'h0000;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_mux};
         s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   // MAC-facing clock-stop and negotiation outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mac_out <= '0;
      end else begin
         mac_out.rx_clk_stop_ok <= rxclk_stop_ff;
         mac_out.tx_clk_stop_ok <= 1'b1;
         mac_out.eee_enabled <= vend_ff[`EEE_BIT_VEND_CAP_EN];
         mac_out.advertise_100 <= vend_ff[`EEE_BIT_VEND_BYPASS] ?
            vend_ff[`EEE_BIT_VEND_CAP_EN] :
            (adv_ff & vend_ff[`EEE_BIT_VEND_CAP_EN]);
      end
   end

   wake_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wake_ff == `EEE_WAKE_MAX && line_in.wake_fail && !wake_rd && !soft_rst)
      |=> wake_ff == `EEE_WAKE_MAX) else $error("wake counter wrapped");
   wake_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wake_rd && !line_in.wake_fail) |=> wake_ff == 16'h0000)
      else $error("wake counter not cleared by read");
   wake_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (line_in.wake_fail && !wake_rd && !soft_rst && wake_ff != `EEE_WAKE_MAX)
      |=> wake_ff == $past(wake_ff) + 16'h0001) else $error("wake miss");
   soft_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      soft_rst |=> wake_ff == 16'h0000 && rxclk_stop_ff) else $error("soft reset");
   rst_selfclr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      soft_rst |=> !soft_rst || $past(wr_go)) else $error("reset bit stuck");
   vend_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (soft_rst && !(wr_go && widx == `EEE_IDX_VEND_CFG)) |=> $stable(vend_ff))
      else $error("vendor reg changed");
   tx_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (line_in.tx_lpi ##1 !soft_rst) |-> tx_rcvd_ff) else $error("tx latch");
   rx_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (line_in.rx_lpi ##1 !soft_rst) |-> rx_rcvd_ff) else $error("rx latch");
   bypass_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
      vend_ff[`EEE_BIT_VEND_BYPASS] |=> mac_out.advertise_100 ==
      $past(vend_ff[`EEE_BIT_VEND_CAP_EN])) else $error("bypass advert");
   lp_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !vend_ff[`EEE_BIT_VEND_CAP_EN] |=> !lp_ff) else $error("partner not ignored");

   wr_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_go);
   wake_rd_c: cover property (@(posedge aclk) disable iff (!aresetn) wake_rd && wake_ff != 0);
   soft_rst_c: cover property (@(posedge aclk) disable iff (!aresetn) soft_rst);
   irq_c: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule // eee_regs

// file: pkg/eee_consts.svh
/*
 Register offsets, field positions, reset values, write mask and wake counter limit of the
 low-power-idle management register set.
 Assumes inclusion by the register-set module and the test bench.
*/
`ifndef EEE_CONSTS_SVH
`define EEE_CONSTS_SVH
`define EEE_IDX_LOOP_BW3 16'h04d6
`define EEE_IDX_VEND_CFG 16'h04d1
`define EEE_IDX_PCS_CTRL 16'h3000
`define EEE_IDX_PCS_STAT 16'h3001
`define EEE_IDX_CAPAB 16'h3014
`define EEE_IDX_WAKE_ERR 16'h3016
`define EEE_IDX_ADVERT 16'h703c
`define EEE_IDX_PARTNER 16'h703d
`define EEE_IDX_IRQ_STAT 16'h7f00
`define EEE_IDX_IRQ_EN 16'h7f01
`define EEE_IDX_IRQ_CLR 16'h7f02
`define EEE_RST_LOOP_BW3 16'h01c1
`define EEE_RST_VEND_CFG 16'h018b
`define EEE_VEND_WR_MASK 16'hfff6
`define EEE_BIT_PCS_RST 15
`define EEE_BIT_RXCLK_STOP 10
`define EEE_BIT_TX_LPI_RCVD 11
`define EEE_BIT_RX_LPI_RCVD 10
`define EEE_BIT_TX_LPI_NOW 9
`define EEE_BIT_RX_LPI_NOW 8
`define EEE_BIT_TXCLK_STOP 6
`define EEE_BIT_CAP_1G 2
`define EEE_BIT_CAP_100 1
`define EEE_BIT_ADV_100 1
`define EEE_BIT_LP_100 1
`define EEE_BIT_VEND_BYPASS 3
`define EEE_BIT_VEND_CAP_EN 0
`define EEE_WAKE_MAX 16'hffff
`endif

// file: pkg/eee_pkg.sv
/*
 Types of the low-power-idle management register set.
 Assumes the constants header is on the include path.
*/
package eee_pkg;
   typedef enum logic [2:0] {
      EEE_W_IDLE = 3'b001,
      EEE_W_RESP = 3'b010,
      EEE_W_HOLD = 3'b100
   } eee_wstate_t;

   typedef struct packed {
      logic tx_lpi;
      logic rx_lpi;
      logic wake_fail;
      logic partner_adv_100;
   } eee_line_t;

   typedef struct packed {
      logic rx_clk_stop_ok;
      logic tx_clk_stop_ok;
      logic advertise_100;
      logic eee_enabled;
   } eee_mac_t;
endpackage

// file: testbench/eee_mac_model.sv
/*
 MAC-side model: drives the line status levels and wake-fault pulses.
 Assumes one aclk domain shared with the register set.
*/
`timescale 1ns/1ps
module eee_mac_model
   import eee_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire eee_mac_t mac_out,
   output eee_line_t line_in,
   output logic tx_stopped
);
   initial line_in = '0;
   // Stops the transmit clock during idle only while stoppable
   always_ff @(posedge aclk) begin
      tx_stopped <= aresetn && line_in.tx_lpi && mac_out.tx_clk_stop_ok;
   end
   task automatic set_lpi(input logic tx, input logic rx, input logic partner);
      @(posedge aclk);
      line_in.tx_lpi <= tx;
      line_in.rx_lpi <= rx;
      line_in.partner_adv_100 <= partner;
   endtask
   // One fault per cycle held high
   task automatic fail_wakes(input int n);
      @(posedge aclk);
      line_in.wake_fail <= 1'b1;
      repeat (n) @(posedge aclk);
      line_in.wake_fail <= 1'b0;
   endtask
endmodule // eee_mac_model

// file: testbench/eee_pcs_register_set_test.sv
/*
 Self-checking bench of the register set over AXI4-Lite.
 Assumes the constants header on the include path and a 100 ns aclk.
*/
`timescale 1ns/1ps
`include "eee_consts.svh"
module eee_pcs_register_set_test
   import eee_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, tx_stopped, adv_strap = 1'b1;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic [1:0] bresp, rresp, last_bresp, last_rresp;
   logic [3:0] wstrb = 4'h3;
   eee_line_t line_in;
   eee_mac_t mac_out;
   int fails = 0;
   int n_checks = 0;
   eee_regs u_eee_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .line_in(line_in), .adv_strap(adv_strap),
      .mac_out(mac_out), .irq(irq));
   eee_mac_model u_eee_mac_model (.aclk(aclk), .aresetn(aresetn), .mac_out(mac_out),
      .line_in(line_in), .tx_stopped(tx_stopped));
   initial forever #50 aclk = ~aclk;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      logic ta, tw, done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= {14'h0, idx, 2'b00};
      wdata <= {16'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         done = bvalid;
         last_bresp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [15:0] idx, input logic [15:0] exp);
      logic ta, done;
      logic [15:0] d;
      done = 1'b0;
      @(posedge aclk);
      araddr <= {14'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         ta = arvalid && arready;
         done = rvalid;
         d = rdata[15:0];
         last_rresp = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      check(what, d, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge aclk);
   endtask
   task automatic report_and_stop();
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge aclk);
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      idle(2);
      check("mac tx stop", mac_out.tx_clk_stop_ok, 1'b1);
      check("mac rx stop", mac_out.rx_clk_stop_ok, 1'b1);
      rd_chk("ctrl", `EEE_IDX_PCS_CTRL, 16'h0400);
      rd_chk("status", `EEE_IDX_PCS_STAT, 16'h0040);
      rd_chk("capab", `EEE_IDX_CAPAB, 16'h0002);
      rd_chk("advert", `EEE_IDX_ADVERT, 16'h0002);
      rd_chk("partner", `EEE_IDX_PARTNER, 16'h0000);
      rd_chk("loop bw", `EEE_IDX_LOOP_BW3, 16'h01c1);
      rd_chk("vendor", `EEE_IDX_VEND_CFG, 16'h018b);
      rd_chk("unmapped", 16'h0100, 16'h0000);
      check("unmapped resp", last_rresp, 2'b10);
      wr(16'h0100, 16'h1234);
      check("unmapped bresp", last_bresp, 2'b00);
      wr(`EEE_IDX_PCS_STAT, 16'hffff);
      wr(`EEE_IDX_CAPAB, 16'hffff);
      wr(`EEE_IDX_PARTNER, 16'hffff);
      wr(`EEE_IDX_LOOP_BW3, 16'hffff);
      wr(`EEE_IDX_PCS_CTRL, 16'h7fff);
      wr(`EEE_IDX_ADVERT, 16'hffff);
      rd_chk("status ro", `EEE_IDX_PCS_STAT, 16'h0040);
      rd_chk("capab ro", `EEE_IDX_CAPAB, 16'h0002);
      rd_chk("partner ro", `EEE_IDX_PARTNER, 16'h0000);
      rd_chk("loop bw ro", `EEE_IDX_LOOP_BW3, 16'h01c1);
      rd_chk("ctrl rsvd", `EEE_IDX_PCS_CTRL, 16'h0400);
      rd_chk("advert rsvd", `EEE_IDX_ADVERT, 16'h0002);
      wr(`EEE_IDX_PCS_CTRL, 16'h0000);
      wr(`EEE_IDX_ADVERT, 16'h0000);
      idle(3);
      rd_chk("ctrl clr", `EEE_IDX_PCS_CTRL, 16'h0000);
      check("mac rx stop off", mac_out.rx_clk_stop_ok, 1'b0);
      check("bypass adv", mac_out.advertise_100, 1'b1);
      wr(`EEE_IDX_VEND_CFG, 16'h0183);
      idle(3);
      check("no bypass adv", mac_out.advertise_100, 1'b0);
      wr(`EEE_IDX_ADVERT, 16'h0002);
      idle(3);
      check("reg adv", mac_out.advertise_100, 1'b1);
      wr(`EEE_IDX_VEND_CFG, 16'h018a);
      idle(3);
      check("eee off", mac_out.eee_enabled, 1'b0);
      check("eee off adv", mac_out.advertise_100, 1'b0);
      wr(`EEE_IDX_VEND_CFG, 16'h0189);
      u_eee_mac_model.set_lpi(1'b1, 1'b0, 1'b1);
      idle(3);
      check("tx clk stopped", tx_stopped, 1'b1);
      rd_chk("tx lpi on", `EEE_IDX_PCS_STAT, 16'h0a40);
      rd_chk("partner on", `EEE_IDX_PARTNER, 16'h0002);
      u_eee_mac_model.set_lpi(1'b0, 1'b1, 1'b0);
      idle(3);
      rd_chk("rx lpi on", `EEE_IDX_PCS_STAT, 16'h0d40);
      u_eee_mac_model.set_lpi(1'b0, 1'b0, 1'b0);
      idle(3);
      rd_chk("lpi latched", `EEE_IDX_PCS_STAT, 16'h0c40);
      u_eee_mac_model.fail_wakes(3);
      rd_chk("wake 3", `EEE_IDX_WAKE_ERR, 16'h0003);
      rd_chk("wake read clr", `EEE_IDX_WAKE_ERR, 16'h0000);
      u_eee_mac_model.fail_wakes(65540);
      rd_chk("wake sat", `EEE_IDX_WAKE_ERR, `EEE_WAKE_MAX);
      u_eee_mac_model.fail_wakes(2);
      @(posedge aclk);
      adv_strap <= 1'b0;
      wr(`EEE_IDX_PCS_CTRL, 16'h8000);
      idle(3);
      rd_chk("ctrl after rst", `EEE_IDX_PCS_CTRL, 16'h0400);
      rd_chk("status after rst", `EEE_IDX_PCS_STAT, 16'h0040);
      rd_chk("wake after rst", `EEE_IDX_WAKE_ERR, 16'h0000);
      rd_chk("advert strap", `EEE_IDX_ADVERT, 16'h0000);
      rd_chk("vendor kept", `EEE_IDX_VEND_CFG, 16'h0189);
      wr(`EEE_IDX_IRQ_CLR, 16'h000f);
      wr(`EEE_IDX_IRQ_EN, 16'h0002);
      rd_chk("irq stat clr", `EEE_IDX_IRQ_STAT, 16'h0000);
      u_eee_mac_model.set_lpi(1'b1, 1'b0, 1'b0);
      idle(3);
      check("irq masked", irq, 1'b0);
      u_eee_mac_model.fail_wakes(1);
      idle(3);
      check("irq raised", irq, 1'b1);
      wr(`EEE_IDX_IRQ_CLR, 16'h0002);
      idle(3);
      check("irq cleared", irq, 1'b0);
      rd_chk("irq stat", `EEE_IDX_IRQ_STAT, 16'h0008);
      rd_chk("irq en", `EEE_IDX_IRQ_EN, 16'h0002);
      rd_chk("irq clr wo", `EEE_IDX_IRQ_CLR, 16'h0000);
      report_and_stop();
   end
endmodule // eee_pcs_register_set_test
